// ==== hdl/dct_pkg.sv ====
// Constants and types shared by the dual counter/timer control block
package dct_pkg;

  // Printed register indices; the byte address is four times the index
  localparam logic [7:0] IDX_WCTRL = 8'h02;
  localparam logic [7:0] IDX_SYNC  = 8'h03;
  localparam logic [7:0] A_WCTRL   = IDX_WCTRL << 2;
  localparam logic [7:0] A_SYNC    = IDX_SYNC << 2;
  localparam logic [7:0] A_WLOAD   = 8'h10;
  localparam logic [7:0] A_WCAP    = 8'h14;
  localparam logic [7:0] A_NLOAD   = 8'h18;
  localparam logic [7:0] A_NCAP    = 8'h1c;
  localparam logic [7:0] A_CFG     = 8'h20;
  localparam logic [7:0] A_STAT    = 8'h24;
  localparam logic [7:0] A_MASK    = 8'h28;

  // Wide-counter control fields
  localparam int B_RUN    = 7;
  localparam int B_SINGLE = 6;
  localparam int B_TOUT   = 5;
  localparam int B_CLK_HI = 4;
  localparam int B_CLK_LO = 3;
  localparam int B_CAPEN  = 2;
  localparam int B_TOEN   = 1;
  localparam int B_ROUTE  = 0;

  // Sync control fields
  localparam int B_SRUN_W = 7;
  localparam int B_SRUN_N = 6;
  localparam int B_SYNC   = 5;

  // Configuration fields
  localparam int B_WDEMOD = 0;
  localparam int B_WES_LO = 1;
  localparam int B_WES_HI = 2;
  localparam int B_NES_LO = 4;
  localparam int B_NES_HI = 5;

  // Interrupt status bits
  localparam int S_TOUT = 0;
  localparam int S_WCAP = 1;
  localparam int S_NCAP = 2;
  localparam int NSTAT  = 3;

  // Values after power-on reset
  localparam logic [15:0] RST_WLOAD = 16'hffff;
  localparam logic [15:0] RST_NLOAD = 16'hffff;
  localparam logic [7:0]  RST_CFG   = 8'h00;
  localparam logic [2:0]  RST_MASK  = 3'h0;

  typedef enum logic [1:0] {
    N_IDLE  = 2'b00,
    N_ARMED = 2'b01,
    N_COUNT = 2'b10
  } dct_nstate_t;

endpackage

// ==== hdl/dct_presc.sv ====
// Prescaler giving a counter tick at the system clock divided by 1, 2, 4, 8
`timescale 1ns/1ns
module dct_presc (
  input  wire logic       core_clk_i,
  input  wire logic       resetn_i,
  input  wire logic [1:0] sel_i,
  output logic            tick_o
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [2:0] mask;

  always_comb begin
    cnt_nxt = cnt_r + 3'h1;
    case (sel_i)
      2'b00:   mask = 3'h0;
      2'b01:   mask = 3'h1;
      2'b10:   mask = 3'h3;
      default: mask = 3'h7;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Free-running divider, so a select change may shorten one period
  assign tick_o = ((cnt_r & mask) == mask);
endmodule

// ==== hdl/dct_sync2.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module dct_sync2 #(
  parameter int W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule

// ==== hdl/dct_top.sv ====
// Dual counter/timer control block with APB registers and interrupt
`timescale 1ns/1ns
module dct_top
  import dct_pkg::*;
#(
  parameter int WW = 16,
  parameter int NW = 8
) (
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        wide_edge_i,
  input  wire logic        narrow_edge_i,
  input  wire logic        port_latch_i,
  input  wire logic        stop_recovery_i,
  output logic             alt_pin_o,
  output logic             irq_o
);
  logic [1:0]        pin_s;
  logic [1:0]        pin_p_r, pin_p_nxt;
  logic              wtick;

  logic [31:0]       prdata_r, prdata_nxt;
  logic              pready_r, pready_nxt;
  logic              pslverr_r, pslverr_nxt;

  logic              wrun_r, wrun_nxt;
  logic              wreq_r, wreq_nxt;
  logic              single_r, single_nxt;
  logic              tout_r, tout_nxt;
  logic [1:0]        csel_r, csel_nxt;
  logic              capen_r, capen_nxt;
  logic              toen_r, toen_nxt;
  logic              route_r, route_nxt;
  logic              nrun_r, nrun_nxt;
  logic              nreq_r, nreq_nxt;
  logic              sync_r, sync_nxt;
  logic [7:0]        cfg_r, cfg_nxt;
  logic [NSTAT-1:0]  stat_r, stat_nxt;
  logic [NSTAT-1:0]  mask_r, mask_nxt;
  logic              irq_r, irq_nxt;
  logic              pin_r, pin_nxt;

  logic [WW-1:0]     wload_r, wload_nxt;
  logic [WW-1:0]     wcnt_r, wcnt_nxt;
  logic [WW-1:0]     wcap_r, wcap_nxt;
  logic              wdone_r, wdone_nxt;
  logic              wout_r, wout_nxt;

  logic [2*NW-1:0]   nload_r, nload_nxt;
  logic [NW-1:0]     ncnt_r, ncnt_nxt;
  logic [NW-1:0]     ncap_rise_r, ncap_rise_nxt;
  logic [NW-1:0]     ncap_fall_r, ncap_fall_nxt;
  dct_nstate_t       nst_r, nst_nxt;

  logic              setup, done, wr, rd, hit;
  logic [31:0]       rmux;
  logic [7:0]        wd;
  logic              w_rise, w_fall, n_rise, n_fall;
  logic              w_edge, n_edge, ntick;
  logic [NSTAT-1:0]  ev, gate;

  dct_sync2 #(
    .W (2)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .async_i    ({narrow_edge_i, wide_edge_i}),
    .sync_o     (pin_s)
  );

  dct_presc u_presc (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .sel_i      (csel_r),
    .tick_o     (wtick)
  );

  always_comb begin
    setup  = psel_i & ~penable_i;
    done   = psel_i & penable_i & pready_r;
    wr     = done & pwrite_i & ~pslverr_r;
    rd     = done & ~pwrite_i & ~pslverr_r;
    wd     = pwdata_i[7:0];
    w_rise = pin_s[0] & ~pin_p_r[0];
    w_fall = ~pin_s[0] & pin_p_r[0];
    n_rise = pin_s[1] & ~pin_p_r[1];
    n_fall = ~pin_s[1] & pin_p_r[1];
    w_edge = (w_rise & cfg_r[B_WES_LO]) | (w_fall & cfg_r[B_WES_HI]);
    n_edge = (n_rise & cfg_r[B_NES_LO]) | (n_fall & cfg_r[B_NES_HI]);
    // Lockstep moves the narrow run change onto the wide tick
    ntick  = sync_r ? wtick : 1'b1;
    ev     = '0;
    hit    = 1'b1;
    case (paddr_i)
      A_WCTRL: rmux = {24'h0, wrun_r, single_r, tout_r, csel_r,
                       capen_r, toen_r, route_r};
      A_SYNC:  rmux = {24'h0, wrun_r, nrun_r, sync_r, 5'h00};
      A_WLOAD: rmux = {{(32-WW){1'b0}}, wload_r};
      A_WCAP:  rmux = {{(32-WW){1'b0}}, wcap_r};
      A_NLOAD: rmux = {{(32-2*NW){1'b0}}, nload_r};
      A_NCAP:  rmux = {{(32-2*NW){1'b0}}, ncap_fall_r, ncap_rise_r};
      A_CFG:   rmux = {24'h0, cfg_r};
      A_STAT:  rmux = {{(32-NSTAT){1'b0}}, stat_r};
      A_MASK:  rmux = {{(32-NSTAT){1'b0}}, mask_r};
      default: begin
        rmux = 32'h0;
        hit  = 1'b0;
      end
    endcase

    pready_nxt  = setup;
    pslverr_nxt = setup & ~hit;
    prdata_nxt  = setup ? rmux : prdata_r;

    wrun_nxt      = wrun_r;
    wreq_nxt      = wreq_r;
    single_nxt    = single_r;
    tout_nxt      = tout_r;
    csel_nxt      = csel_r;
    capen_nxt     = capen_r;
    toen_nxt      = toen_r;
    route_nxt     = route_r;
    nrun_nxt      = nrun_r;
    nreq_nxt      = nreq_r;
    sync_nxt      = sync_r;
    cfg_nxt       = cfg_r;
    mask_nxt      = mask_r;
    wload_nxt     = wload_r;
    nload_nxt     = nload_r;
    wcnt_nxt      = wcnt_r;
    wcap_nxt      = wcap_r;
    wdone_nxt     = wdone_r;
    wout_nxt      = wout_r;
    ncnt_nxt      = ncnt_r;
    ncap_rise_nxt = ncap_rise_r;
    ncap_fall_nxt = ncap_fall_r;
    nst_nxt       = nst_r;
    pin_p_nxt     = pin_s;

    if (wr) begin
      case (paddr_i)
        A_WCTRL: begin
          wreq_nxt   = wd[B_RUN];
          single_nxt = wd[B_SINGLE];
          csel_nxt   = wd[B_CLK_HI:B_CLK_LO];
          capen_nxt  = wd[B_CAPEN];
          toen_nxt   = wd[B_TOEN];
          route_nxt  = wd[B_ROUTE];
        end
        A_SYNC: begin
          wreq_nxt = wd[B_SRUN_W];
          nreq_nxt = wd[B_SRUN_N];
          sync_nxt = wd[B_SYNC];
        end
        A_WLOAD: wload_nxt = pwdata_i[WW-1:0];
        A_NLOAD: nload_nxt = pwdata_i[2*NW-1:0];
        A_CFG:   cfg_nxt = wd;
        A_MASK:  mask_nxt = pwdata_i[NSTAT-1:0];
        default: begin
        end
      endcase
    end

    // Run request is applied on the next counter tick, not at the write
    if (wtick && (wreq_r != wrun_r)) begin
      wrun_nxt  = wreq_r;
      wcnt_nxt  = wload_r;
      wdone_nxt = 1'b0;
    end else if (wrun_r && cfg_r[B_WDEMOD]) begin
      if (w_edge && !(single_r && wdone_r)) begin
        wcap_nxt       = wload_r - wcnt_r;
        wcnt_nxt       = wload_r;
        wdone_nxt      = 1'b1;
        ev[S_WCAP]     = 1'b1;
      end else if (wtick) begin
        if (wcnt_r == '0) begin
          ev[S_TOUT] = 1'b1;
          wcnt_nxt   = wload_r;
        end else begin
          wcnt_nxt = wcnt_r - 1'b1;
        end
      end
    end else if (wrun_r && wtick) begin
      if (wcnt_r == '0) begin
        ev[S_TOUT] = 1'b1;
        wout_nxt   = ~wout_r;
        if (single_r) begin
          wrun_nxt = 1'b0;
          wreq_nxt = 1'b0;
        end else begin
          wcnt_nxt = wload_r;
        end
      end else begin
        wcnt_nxt = wcnt_r - 1'b1;
      end
    end

    if (ntick && (nreq_r != nrun_r)) begin
      nrun_nxt = nreq_r;
    end
    case (nst_r)
      N_IDLE: begin
        if (nrun_r) begin
          nst_nxt = N_ARMED;
        end
      end
      N_ARMED: begin
        if (!nrun_r) begin
          nst_nxt = N_IDLE;
        end else if (n_edge) begin
          nst_nxt  = N_COUNT;
          ncnt_nxt = nload_r[NW-1:0];
        end
      end
      N_COUNT: begin
        if (!nrun_r) begin
          nst_nxt = N_IDLE;
        end else if (n_edge) begin
          if (n_rise) begin
            ncap_rise_nxt = ~ncnt_r;
          end else begin
            ncap_fall_nxt = ~ncnt_r;
          end
          ncnt_nxt   = nload_r[NW-1:0];
          ev[S_NCAP] = 1'b1;
        end else begin
          // Plain wrap from zero; no flag is raised
          ncnt_nxt = ncnt_r - 1'b1;
        end
      end
      default: nst_nxt = N_IDLE;
    endcase

    // Flag set beats a write clear landing in the same cycle
    tout_nxt = tout_r | ev[S_TOUT];
    if (wr && (paddr_i == A_WCTRL) && wd[B_TOUT] && !ev[S_TOUT]) begin
      tout_nxt = 1'b0;
    end

    // Read clears only the bits that the read actually returned
    stat_nxt = stat_r | ev;
    if (rd && (paddr_i == A_STAT)) begin
      stat_nxt = (stat_r & ~prdata_r[NSTAT-1:0]) | ev;
    end

    if (stop_recovery_i) begin
      wrun_nxt   = 1'b0;
      wreq_nxt   = 1'b0;
      single_nxt = 1'b0;
      tout_nxt   = 1'b0;
      toen_nxt   = 1'b0;
      route_nxt  = 1'b0;
      nrun_nxt   = 1'b0;
      nreq_nxt   = 1'b0;
      nst_nxt    = N_IDLE;
    end

    gate    = {1'b1, capen_r, toen_r};
    irq_nxt = |(stat_r & mask_r & gate);
    pin_nxt = route_r ? wout_r : port_latch_i;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_r    <= 32'h0;
      pready_r    <= 1'b0;
      pslverr_r   <= 1'b0;
      pin_p_r     <= 2'h0;
      wrun_r      <= 1'b0;
      wreq_r      <= 1'b0;
      single_r    <= 1'b0;
      tout_r      <= 1'b0;
      csel_r      <= 2'h0;
      capen_r     <= 1'b0;
      toen_r      <= 1'b0;
      route_r     <= 1'b0;
      nrun_r      <= 1'b0;
      nreq_r      <= 1'b0;
      sync_r      <= 1'b0;
      cfg_r       <= RST_CFG;
      stat_r      <= '0;
      mask_r      <= RST_MASK;
      irq_r       <= 1'b0;
      pin_r       <= 1'b0;
      wload_r     <= RST_WLOAD[WW-1:0];
      wcnt_r      <= '0;
      wcap_r      <= '0;
      wdone_r     <= 1'b0;
      wout_r      <= 1'b0;
      nload_r     <= RST_NLOAD[2*NW-1:0];
      ncnt_r      <= '0;
      ncap_rise_r <= '0;
      ncap_fall_r <= '0;
      nst_r       <= N_IDLE;
    end else begin
      prdata_r    <= prdata_nxt;
      pready_r    <= pready_nxt;
      pslverr_r   <= pslverr_nxt;
      pin_p_r     <= pin_p_nxt;
      wrun_r      <= wrun_nxt;
      wreq_r      <= wreq_nxt;
      single_r    <= single_nxt;
      tout_r      <= tout_nxt;
      csel_r      <= csel_nxt;
      capen_r     <= capen_nxt;
      toen_r      <= toen_nxt;
      route_r     <= route_nxt;
      nrun_r      <= nrun_nxt;
      nreq_r      <= nreq_nxt;
      sync_r      <= sync_nxt;
      cfg_r       <= cfg_nxt;
      stat_r      <= stat_nxt;
      mask_r      <= mask_nxt;
      irq_r       <= irq_nxt;
      pin_r       <= pin_nxt;
      wload_r     <= wload_nxt;
      wcnt_r      <= wcnt_nxt;
      wcap_r      <= wcap_nxt;
      wdone_r     <= wdone_nxt;
      wout_r      <= wout_nxt;
      nload_r     <= nload_nxt;
      ncnt_r      <= ncnt_nxt;
      ncap_rise_r <= ncap_rise_nxt;
      ncap_fall_r <= ncap_fall_nxt;
      nst_r       <= nst_nxt;
    end
  end

  assign prdata_o  = prdata_r;
  assign pready_o  = pready_r;
  assign pslverr_o = pslverr_r;
  assign alt_pin_o = pin_r;
  assign irq_o     = irq_r;
endmodule

// ==== verif/dct_top_assertions.sv ====
// Port-level assertions for the dual counter/timer control block
`timescale 1ns/1ns
module dct_top_assertions
  import dct_pkg::*;
#(
  parameter int WW = 16,
  parameter int NW = 8
) (
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        wide_edge_i,
  input wire logic        narrow_edge_i,
  input wire logic        port_latch_i,
  input wire logic        stop_recovery_i,
  input wire logic        alt_pin_o,
  input wire logic        irq_o
);
  logic mapped;
  assign mapped = paddr_i inside {A_WCTRL, A_SYNC, A_WLOAD, A_WCAP,
                                  A_NLOAD, A_NCAP, A_CFG, A_STAT, A_MASK};
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_commit(a);
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == a;
  endsequence
  chk_ready_setup: assert property (s_setup |=> pready_o)
    else $error("no ready after setup");
  chk_ready_single: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  chk_ready_cause: assert property ($rose(pready_o) |->
    $past(psel_i && !penable_i))
    else $error("ready without setup");
  chk_err_zero: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("error response with data");
  chk_err_map: assert property (pready_o |-> pslverr_o == !mapped)
    else $error("error flag wrong for address");
  chk_recov_clear: assert property ($past(stop_recovery_i, 2) &&
    pready_o && !pwrite_i && paddr_i == A_WCTRL |->
    (prdata_o & 32'he3) == 32'h0)
    else $error("control not cleared by recovery");
  chk_mask_quiet: assert property (s_commit(A_MASK) ##0
    (pwdata_i[2:0] == 3'h0) |-> ##2 !irq_o)
    else $error("interrupt while fully masked");
  chk_route_latch: assert property (s_commit(A_WCTRL) ##0 !pwdata_i[0]
    |-> ##2 alt_pin_o == $past(port_latch_i))
    else $error("pin not from port latch");
endmodule

bind dct_top dct_top_assertions #(.WW(WW), .NW(NW)) dct_top_assertions_inst (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .wide_edge_i(wide_edge_i),
  .narrow_edge_i(narrow_edge_i), .port_latch_i(port_latch_i),
  .stop_recovery_i(stop_recovery_i), .alt_pin_o(alt_pin_o), .irq_o(irq_o));

// ==== verif/test_dct_top.sv ====
// Self-checking bench for the dual counter/timer control block
`timescale 1ns/1ns
module test_dct_top
  import dct_pkg::*;
;
  logic        core_clk_i, resetn_i, psel_i, penable_i, pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic        pready_o, pslverr_o, wide_edge_i, narrow_edge_i;
  logic        port_latch_i, stop_recovery_i, alt_pin_o, irq_o;
  int          errors, compares, seed, n, ld, gap;
  logic [33:0] q[$];
  logic [33:0] note;
  logic [7:0]  wctl[3] = '{8'h84, 8'hc4, 8'h80};
  logic [7:0]  stat2[3] = '{8'h02, 8'h00, 8'h02};

  dct_top dct_top_inst (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .wide_edge_i(wide_edge_i),
    .narrow_edge_i(narrow_edge_i), .port_latch_i(port_latch_i),
    .stop_recovery_i(stop_recovery_i), .alt_pin_o(alt_pin_o), .irq_o(irq_o));

  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic report_and_stop;
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Expectation is noted first; the monitor below does the compare
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic e, input logic [31:0] x);
    q.push_back({~w, e, x});
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    // No local limit: a hung slave is caught by the watchdog
    do begin
      @(posedge core_clk_i);
    end while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0, 1'b0, x);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 1'b0, 32'h0);
  endtask

  task automatic wait_chg(output int c);
    logic v;
    v = alt_pin_o;
    c = 0;
    do begin
      @(posedge core_clk_i);
      c++;
    end while (alt_pin_o === v && c < 300);
  endtask

  task automatic pulse_wide;
    wide_edge_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    wide_edge_i <= 1'b0;
    repeat (8) @(posedge core_clk_i);
  endtask

  always @(posedge core_clk_i) begin
    if (pready_o === 1'b1) begin
      if (q.size() == 0) errors++;
      else begin
        note = q.pop_front();
        chk({31'h0, pslverr_o}, {31'h0, note[32]});
        if (note[33]) chk(prdata_o, note[31:0]);
      end
    end
  end

  // Random port latch keeps the routed-pin check honest
  always @(posedge core_clk_i) port_latch_i <= 1'($random(seed));

  initial begin
    repeat (20000) @(posedge core_clk_i);
    errors++;
    report_and_stop;
  end

  initial begin
    seed = 68;
    {resetn_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {wide_edge_i, narrow_edge_i, stop_recovery_i} = '0;
    repeat (10) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    @(posedge core_clk_i);
    rd(A_WCTRL, 32'h0);
    rd(A_SYNC, 32'h0);
    xfer(1'b0, 8'h40, 32'h0, 1'b1, 32'h0);
    xfer(1'b1, 8'h44, 32'hff, 1'b1, 32'h0);
    wr(A_WCTRL, 32'h7f);
    rd(A_WCTRL, 32'h5f);
    wr(A_SYNC, 32'h20);
    stop_recovery_i <= 1'b1;
    @(posedge core_clk_i);
    stop_recovery_i <= 1'b0;
    rd(A_WCTRL, 32'h1c);
    rd(A_SYNC, 32'h20);
    ld = 1 + ($random(seed) & 15);
    wr(A_WLOAD, ld);
    wr(A_MASK, 32'h1);
    wr(A_WCTRL, 32'h42);
    wr(A_WCTRL, 32'hc2);
    n = 0;
    while (irq_o !== 1'b1 && n < 100) begin
      @(posedge core_clk_i);
      n++;
    end
    chk(n, ld + 3);
    rd(A_WCTRL, 32'h62);
    wr(A_MASK, 32'h0);
    @(posedge core_clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wr(A_MASK, 32'h1);
    @(posedge core_clk_i);
    chk({31'h0, irq_o}, 32'h1);
    rd(A_STAT, 32'h1);
    rd(A_STAT, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    wr(A_WCTRL, 32'h42);
    rd(A_WCTRL, 32'h62);
    wr(A_WCTRL, 32'h62);
    rd(A_WCTRL, 32'h42);
    wr(A_WLOAD, 32'h3);
    for (int s = 0; s < 4; s++) begin
      wr(A_WCTRL, 32'h81 | (s << 3));
      wait_chg(n);
      wait_chg(n);
      wait_chg(n);
      chk(n, 4 << s);
      rd(A_WCTRL, 32'ha1 | (s << 3));
      wr(A_WCTRL, 32'h0);
    end
    repeat (10) @(posedge core_clk_i);
    rd(A_STAT, 32'h1);
    wr(A_WLOAD, 32'hffff);
    wr(A_CFG, 32'h03);
    wr(A_MASK, 32'h2);
    for (int k = 0; k < 3; k++) begin
      wr(A_WCTRL, {24'h0, wctl[k]});
      pulse_wide();
      chk({31'h0, irq_o}, {31'h0, wctl[k][2]});
      rd(A_STAT, 32'h2);
      // Start, then two ticks pass before the synced edge is seen
      rd(A_WCAP, 32'h2);
      pulse_wide();
      rd(A_STAT, {24'h0, stat2[k]});
      wr(A_WCTRL, 32'h0);
    end
    gap = 270 + ($random(seed) & 63);
    wr(A_CFG, 32'h10);
    wr(A_NLOAD, 32'hffff);
    wr(A_MASK, 32'h4);
    wr(A_SYNC, 32'h40);
    rd(A_SYNC, 32'h40);
    narrow_edge_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    narrow_edge_i <= 1'b0;
    repeat (gap - 14) @(posedge core_clk_i);
    rd(A_STAT, 32'h0);
    repeat (7) @(posedge core_clk_i);
    narrow_edge_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    narrow_edge_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    chk({31'h0, irq_o}, 32'h1);
    rd(A_NCAP, {24'h0, 8'(gap - 1)});
    rd(A_STAT, 32'h4);
    wr(A_SYNC, 32'h0);
    report_and_stop;
  end
endmodule
